// file: hw/lfwa_pkg.sv
/*
 Shared constants and types of the lost-frame waveform adjuster.
 Assumes Q8.8 log energies, Q1.15 correlations and 16-bit signed samples.
*/
package lfwa_pkg;

   // Sample and fixed-point formats
   localparam int                 SAMPLE_W  = 16;
   localparam int                 ENER_W    = 16;
   localparam int                 ZC_W      = 9;
   localparam int                 Q15_SHIFT = 15;
   localparam logic        [16:0] Q15_ONE   = 17'h08000;

   // Long-term energy average, Q8.8
   localparam logic [ENER_W-1:0]  ENER_INIT     = 16'h3B6D;
   localparam logic [ENER_W-1:0]  ENER_FLOOR    = 16'h3200;
   localparam logic [ENER_W-1:0]  ENER_DROP_SIL = 16'h0800;
   localparam logic [ENER_W-1:0]  ENER_DROP     = 16'h0600;
   localparam logic [ENER_W-1:0]  ENER_RISE     = 16'h0100;
   localparam logic        [15:0] MEAN_KEEP     = 16'h7D71;
   localparam logic        [15:0] MEAN_NEW      = 16'h028F;

   // Correlation thresholds, Q1.15
   localparam logic        [15:0] CORR_SIL = 16'h7333;
   localparam logic        [15:0] CORR_HI  = 16'h6666;
   localparam logic        [15:0] CORR_MID = 16'h4CCD;

   // Zero-crossing thresholds
   localparam logic   [ZC_W-1:0]  ZC_LIMIT       = 9'h064;
   localparam logic   [ZC_W-1:0]  ZC_FIRST_SHORT = 9'h046;
   localparam logic   [ZC_W-1:0]  ZC_FIRST_LONG  = 9'h069;
   localparam int                 SHORT_FRAME    = 256;

   // Harmonic ratio test: num * 10 >= den * 7
   localparam logic         [3:0] HARM_NUM_K = 4'h7;
   localparam logic         [3:0] HARM_DEN_K = 4'hA;

   // Additive signal: high-pass zero and level smoothing, Q1.15
   localparam logic        [16:0] HP_COEF    = 17'h0570A;
   localparam logic        [16:0] LEVEL_KEEP = 17'h07EB8;
   localparam logic        [16:0] LEVEL_NEW  = 17'h00148;

   // Loss run counting
   localparam logic         [3:0] LOSS_OLA = 4'h4;
   localparam logic         [3:0] LOSS_MAX = 4'hF;

   typedef enum logic [1:0] {MODE_PASS, MODE_REP, MODE_OLA_INIT, MODE_OLA_GOOD} lfwa_mode_t;

endpackage : lfwa_pkg

// file: hw/lfwa_skid2.sv
/*
 Two-entry elastic buffer with valid/ready on both sides.
 Assumes one clock; outputs and in_ready come straight from flip-flops.
*/
`timescale 1ns/100ps
module lfwa_skid2
   import lfwa_pkg::*;
#(
   parameter int W = 17
)
(
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // Fill side
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);

   logic         tail_v;
   logic [W-1:0] tail_d;
   logic         push;
   logic         head_free;

   assign push      = in_valid && in_ready;
   assign head_free = !out_valid || out_ready;

   // Head refills from the tail first so word order is kept
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         out_valid <= 1'b0;
         out_data  <= '0;
         tail_v    <= 1'b0;
         tail_d    <= '0;
         in_ready  <= 1'b1;
      end
      else if (head_free)
      begin
         if (tail_v)
         begin
            out_data <= tail_d;
            out_valid <= 1'b1;
            tail_v   <= push;
            tail_d   <= in_data;
            in_ready <= !push;
         end
         else
         begin
            out_valid <= push;
            out_data  <= in_data;
            in_ready  <= 1'b1;
         end
      end
      else if (push)
      begin
         tail_v   <= 1'b1;
         tail_d   <= in_data;
         in_ready <= 1'b0;       // Stall the source while both entries hold words
      end
   end

endmodule : lfwa_skid2

// file: hw/lfwa_pitch_judge.sv
/*
 Combinational pitch usability decision for the first frame of a loss run.
 Assumes all inputs describe the frame before the loss and are stable.
*/
`timescale 1ns/100ps
module lfwa_pitch_judge
   import lfwa_pkg::*;
#(
   parameter int FRAME_LEN = 256
)
(
   // Prior frame description
   input  wire logic [ENER_W-1:0] prior_energy,
   input  wire logic [ENER_W-1:0] ener_mean,
   input  wire logic   [ZC_W-1:0] prior_crossings,
   input  wire logic   [ZC_W-1:0] first_loss_crossing_count,
   input  wire logic       [15:0] peak_corr,
   input  wire logic       [47:0] harm_num,
   input  wire logic       [47:0] harm_den,
   // Verdict
   output      logic              usable
);

   logic [ENER_W:0] mean_x;
   logic [ENER_W:0] ener_x;
   logic [51:0]     harm_lhs;
   logic [51:0]     harm_rhs;
   logic [ZC_W-1:0] first_zc_lim;

   assign mean_x       = {1'b0, ener_mean};
   assign ener_x       = {1'b0, prior_energy};
   assign harm_lhs     = 52'(harm_num) * 52'(HARM_DEN_K);
   assign harm_rhs     = 52'(harm_den) * 52'(HARM_NUM_K);
   assign first_zc_lim = (FRAME_LEN <= SHORT_FRAME) ? ZC_FIRST_SHORT : ZC_FIRST_LONG;

   // Ordered tests: the first one that matches decides
   always_comb
   begin
      if (first_loss_crossing_count > first_zc_lim)
         usable = 1'b0;
      else if (prior_energy < ENER_FLOOR ||
               (peak_corr < CORR_SIL && mean_x > ener_x + 17'(ENER_DROP_SIL)))
         usable = 1'b0;
      else if (peak_corr > CORR_HI)
         usable = 1'b1;
      else if (prior_crossings > ZC_LIMIT)
         usable = 1'b0;
      else if (mean_x > ener_x + 17'(ENER_DROP))
         usable = 1'b0;
      else if (ener_x > mean_x + 17'(ENER_RISE) && peak_corr > CORR_MID)
         usable = 1'b1;
      else
         usable = (harm_lhs >= harm_rhs);
   end

endmodule : lfwa_pitch_judge

// file: hw/lfwa_adjust.sv
/*
 Time-domain waveform adjuster for concealed audio frames.
 Holds the long-term energy average, judges the pitch once per loss run,
 rebuilds lost frames by pitch repetition, adds a high-passed additive
 signal and cross-fades into the first good frame after a run of at most three lost frames. Assumes an upstream
 decoder that sends the prior spectrum, then one frame of samples whose
 first sample carries the frame descriptor; descriptor inputs are stable
 from the first spectrum bin to the first sample.
*/
`timescale 1ns/100ps

module lfwa_adjust
   import lfwa_pkg::*;
#(
   parameter int FRAME_LEN = 256
)
(
   // Clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   // Initially concealed or decoded samples
   input  wire logic                       in_valid,
   output      logic                       in_ready,
   input  wire logic signed [SAMPLE_W-1:0] in_sample,
   input  wire logic                       in_first,
   // Frame descriptor, sampled with the first sample
   input  wire logic                       frame_lost,
   input  wire logic [$clog2(FRAME_LEN)-1:0] pitch_period,
   input  wire logic               [15:0]  peak_corr,
   input  wire logic         [ENER_W-1:0]  prior_energy,
   input  wire logic           [ZC_W-1:0]  prior_crossings,
   input  wire logic           [ZC_W-1:0]  first_loss_crossing_count,
   // Spectrum of the frame before the current one
   input  wire logic                       spec_valid,
   input  wire logic signed [SAMPLE_W-1:0] spec_coef,
   input  wire logic                       spec_last,
   // Adjusted samples
   output      logic                       out_valid,
   input  wire logic                       out_ready,
   output      logic signed [SAMPLE_W-1:0] out_sample,
   output      logic                       out_first,
   // Status
   output      logic                       pitch_usable,
   output      logic                 [3:0] loss_count
);

   localparam int IW = $clog2(FRAME_LEN);
   localparam int SW = IW - 2;

   if ((1 << IW) != FRAME_LEN || FRAME_LEN < 16)
   begin : g_len_check
      $error("FRAME_LEN must be a power of two of at least 16");
   end

   // Frame and run state
   logic          [IW-1:0] n_reg;
   logic          [IW-1:0] q_reg;
   logic          [IW-1:0] pitch_reg;
   logic            [15:0] corr_reg;
   logic                   fade_reg;
   lfwa_mode_t             mode_reg;
   logic      [ENER_W-1:0] ener_mean;
   logic            [16:0] level;
   logic signed [SAMPLE_W-1:0] src_prev;
   logic                   rd_bank;

   // Storage
   logic signed [SAMPLE_W-1:0] hist     [2][FRAME_LEN];
   logic signed [SAMPLE_W-1:0] prev_init[FRAME_LEN];
   logic signed [SAMPLE_W-1:0] seed     [FRAME_LEN/4];

   // Harmonic accumulation
   logic            [47:0] harm_num;
   logic            [47:0] harm_den;
   logic signed     [IW+4:0] harm_err;
   logic                   spec_fresh;

   // Combinational frame and sample terms
   logic                   acc;
   logic                   first_loss;
   logic                   judged;
   logic                   usable_now;
   logic             [3:0] next_loss;
   lfwa_mode_t             next_mode;
   lfwa_mode_t             mode_now;
   logic                   fade_now;
   logic          [IW-1:0] pitch_now;
   logic            [15:0] corr_now;
   logic          [IW-1:0] cur_n;
   logic          [IW-1:0] cur_q;
   logic          [IW-1:0] quarter;
   logic            [16:0] step;
   logic            [16:0] weight;
   logic            [16:0] level_cur;
   logic            [16:0] level_target;
   logic            [16:0] next_level;
   logic          [IW-1:0] rd_idx;
   logic signed [SAMPLE_W-1:0] rep_new;
   logic signed [SAMPLE_W-1:0] rep_old;
   logic signed [SAMPLE_W-1:0] src_cur;
   logic signed     [39:0] buf_val;
   logic signed     [39:0] hp_val;
   logic signed     [39:0] noise;
   logic signed     [39:0] blend;
   logic signed [SAMPLE_W-1:0] next_out;
   logic                   skid_valid;

   // Clamp a wide result into the sample range
   function automatic logic signed [SAMPLE_W-1:0] sat16(input logic signed [39:0] v);
      if (v > 40'sh0000007FFF)
         return 16'sh7FFF;
      else if (v < -40'sh0000008000)
         return -16'sh8000;
      else
         return v[SAMPLE_W-1:0];
   endfunction : sat16

   assign acc        = in_valid && in_ready;
   assign first_loss = frame_lost && (loss_count == 4'h0);

   lfwa_pitch_judge #(
      .FRAME_LEN                 (FRAME_LEN)
   ) u_judge (
      .prior_energy              (prior_energy),
      .ener_mean                 (ener_mean),
      .prior_crossings           (prior_crossings),
      .first_loss_crossing_count (first_loss_crossing_count),
      .peak_corr                 (peak_corr),
      .harm_num                  (harm_num),
      .harm_den                  (harm_den),
      .usable                    (judged)
   );

   // Frame decision, meaningful only on the first sample of a frame
   always_comb
   begin
      usable_now = first_loss ? judged : pitch_usable;
      next_loss  = loss_count;
      next_mode  = MODE_PASS;
      if (frame_lost)
      begin
         if (loss_count != LOSS_MAX)
            next_loss = loss_count + 4'h1;
         if (!usable_now)
            next_mode = MODE_PASS;
         else if (next_loss > LOSS_OLA)
            next_mode = MODE_PASS;
         else if (next_loss == LOSS_OLA)
            next_mode = MODE_OLA_INIT;
         else
            next_mode = MODE_REP;
      end
      else
      begin
         next_loss = 4'h0;
         if (loss_count != 4'h0 && loss_count < LOSS_OLA && pitch_usable)
            next_mode = MODE_OLA_GOOD;
      end
   end

   // First sample takes fresh decisions; the rest use the held ones
   always_comb
   begin
      mode_now  = in_first ? next_mode : mode_reg;
      fade_now  = in_first ? (first_loss && next_mode == MODE_REP) : fade_reg;
      pitch_now = (in_first && first_loss) ? pitch_period : pitch_reg;
      corr_now  = (in_first && first_loss) ? peak_corr : corr_reg;
      cur_n     = in_first ? '0 : n_reg;
      cur_q     = in_first ? '0 : q_reg;
      quarter   = (pitch_now < IW'(4)) ? IW'(1) : (pitch_now >> 2);
   end

   // Pitch repetition source and quarter-pitch head cross-fade
   always_comb
   begin
      step    = 17'(Q15_ONE / 17'(quarter));
      rd_idx  = IW'(FRAME_LEN - int'(pitch_now) + int'(cur_q));
      rep_new = hist[rd_bank][rd_idx];
      rep_old = (cur_n < quarter) ? in_sample : seed[SW'(cur_q)];
      weight  = Q15_ONE;
      if (fade_now && cur_q < quarter)
         weight = 17'(32'(cur_q) * 32'(step));
      buf_val = (40'(rep_old) * $signed(40'(Q15_ONE - weight)) +
                 40'(rep_new) * $signed(40'(weight))) >>> Q15_SHIFT;
   end

   // High-passed additive signal scaled by the smoothed level
   always_comb
   begin
      src_cur      = fade_now ? hist[rd_bank][cur_n] : prev_init[cur_n];
      hp_val       = 40'(src_cur) - ((40'(src_prev) * $signed(40'(HP_COEF))) >>> Q15_SHIFT);
      if (cur_n == '0)
         hp_val = 40'(src_cur);                                 // No history across frames
      level_cur    = (in_first && first_loss) ? 17'h00000 : level;
      level_target = Q15_ONE - 17'(corr_now >> 1);
      next_level   = 17'((34'(level_cur) * 34'(LEVEL_KEEP) +
                          34'(level_target) * 34'(LEVEL_NEW)) >> Q15_SHIFT);
      noise        = (hp_val * $signed(40'(level_cur))) >>> Q15_SHIFT;
   end

   // Output selection; the additive signal always joins before any blend
   always_comb
   begin
      blend = ((buf_val + noise) * 40'(FRAME_LEN - int'(cur_n)) +
               40'(in_sample) * $signed(40'(cur_n))) >>> IW;
      case (mode_now)
         MODE_PASS:     next_out = in_sample;
         MODE_REP:      next_out = sat16(buf_val + noise);
         MODE_OLA_INIT: next_out = sat16(blend);
         MODE_OLA_GOOD: next_out = sat16(blend);
         default:       next_out = in_sample;
      endcase
   end

   // Sample and period position counters
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         n_reg <= '0;
         q_reg <= '0;
      end
      else if (acc)
      begin
         n_reg <= cur_n + IW'(1);
         q_reg <= (cur_q + IW'(1) >= pitch_now) ? '0 : cur_q + IW'(1);
      end
   end

   // Per-frame decisions held for the rest of the frame and the run
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         mode_reg     <= MODE_PASS;
         fade_reg     <= 1'b0;
         loss_count   <= 4'h0;
         pitch_usable <= 1'b0;
         pitch_reg    <= '0;
         corr_reg     <= '0;
      end
      else if (acc && in_first)
      begin
         mode_reg   <= next_mode;
         fade_reg   <= fade_now;
         loss_count <= next_loss;
         if (first_loss)
         begin
            pitch_usable <= judged;
            pitch_reg    <= pitch_period;
            corr_reg     <= peak_corr;
         end
      end
   end

   // Long-term energy average, updated from frame descriptors with energy above ENER_FLOOR and crossings below ZC_LIMIT
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         ener_mean <= ENER_INIT;
      else if (acc && in_first && prior_energy > ENER_FLOOR && prior_crossings < ZC_LIMIT)
         ener_mean <= ENER_W'((32'(ener_mean) * 32'(MEAN_KEEP) +
                               32'(prior_energy) * 32'(MEAN_NEW)) >> Q15_SHIFT);
   end

   // Harmonic energy: err tracks 2*(k*T - i*2L); a bin hits when -T <= err < T
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         harm_num   <= '0;
         harm_den   <= '0;
         harm_err   <= '0;
         spec_fresh <= 1'b1;
      end
      else if (spec_valid)
      begin
         logic signed [IW+4:0] e;
         logic                 hit;
         logic          [47:0] sq;
         logic signed [IW+4:0] tp;
         e   = spec_fresh ? -(IW+5)'(4 * FRAME_LEN) : harm_err;
         tp  = (IW+5)'(pitch_period);
         hit = (e >= -tp) && (e < tp);      // Signed bounds; unsigned ones never match
         sq  = 48'(32'(spec_coef * spec_coef));
         harm_den   <= (spec_fresh ? 48'h0 : harm_den) + sq;
         harm_num   <= (spec_fresh ? 48'h0 : harm_num) + (hit ? sq : 48'h0);
         harm_err   <= e + (IW+5)'(2 * int'(pitch_period)) - (hit ? (IW+5)'(4 * FRAME_LEN) : '0);
         spec_fresh <= spec_last;
      end
   end

   // Additive level and filter history advance on every accepted sample
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         level    <= '0;
         src_prev <= '0;
      end
      else if (acc)
      begin
         level    <= next_level;
         src_prev <= src_cur;
      end
   end

   // Two history banks: repetition reads the tail of one while the other fills
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         rd_bank <= 1'b0;
      else if (acc && cur_n == IW'(FRAME_LEN - 1))
         rd_bank <= !rd_bank;
   end

   always_ff @(posedge clk_sys)
   begin
      if (acc)
      begin
         hist[!rd_bank][cur_n] <= next_out;
         if (mode_now != MODE_OLA_GOOD && (in_first ? frame_lost : loss_count != 4'h0))
            prev_init[cur_n] <= in_sample;
         if (fade_now && cur_n < quarter)
            seed[SW'(cur_n)] <= in_sample;
      end
   end

   // Two-entry buffer absorbs a receiver stall without losing a word
   lfwa_skid2 #(
      .W         (SAMPLE_W + 1)
   ) u_skid (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .in_data   ({in_first, next_out}),
      .out_valid (skid_valid),
      .out_ready (out_ready),
      .out_data  ({out_first, out_sample})
   );

   assign out_valid = skid_valid;

endmodule : lfwa_adjust

// file: sim/lfwa_adjust_properties.sv
/* Port checker for lfwa_adjust: handshake, buffer fill, loss count, first-loss verdict.
   Assumes one clock domain; bound to every lfwa_adjust instance. */
`timescale 1ns/100ps
module lfwa_adjust_chk
   import lfwa_pkg::*;
#(
   parameter int FRAME_LEN = 256
)
(
   // Clock and reset
   input wire logic                       clk_sys,
   input wire logic                       rst_n,
   // Watched ports
   input wire logic                       in_valid,
   input wire logic                       in_ready,
   input wire logic                       in_first,
   input wire logic                       frame_lost,
   input wire logic         [ENER_W-1:0]  prior_energy,
   input wire logic           [ZC_W-1:0]  first_loss_crossing_count,
   input wire logic                       out_valid,
   input wire logic                       out_ready,
   input wire logic signed [SAMPLE_W-1:0] out_sample,
   input wire logic                       out_first,
   input wire logic                       pitch_usable,
   input wire logic                 [3:0] loss_count
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic                         [1:0] occ;
   logic       [$clog2(FRAME_LEN)-1:0] ocnt;
   wire  head = in_valid && in_ready && in_first && frame_lost;
   wire  zlim = first_loss_crossing_count >
               ((FRAME_LEN <= SHORT_FRAME) ? ZC_FIRST_SHORT : ZC_FIRST_LONG);

   // Words held and position in output frame; a lost word shows as a wrong count
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         {occ, ocnt} <= '0;
      else
      begin
         occ <= occ + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
         ocnt <= ocnt + ($clog2(FRAME_LEN))'(out_valid && out_ready);
      end
   end

   AST_RESET_IDLE: assert property ($rose(rst_n) |-> !out_valid && in_ready
      && !pitch_usable && loss_count == 4'h0) else $error("state after reset wrong");
   AST_OUT_STANDS: assert property (out_valid && !out_ready |=> out_valid
      && $stable(out_sample) && $stable(out_first)) else $error("output dropped while stalled");
   AST_VALID_OCC: assert property (out_valid == (occ != 2'h0))
      else $error("output valid does not match held words");
   AST_READY_FULL: assert property (!in_ready |-> occ == 2'h2)
      else $error("input refused with room left");
   AST_FIRST_PACE: assert property (out_valid && out_ready && out_first |-> ocnt == '0)
      else $error("frame start misplaced");
   AST_LOSS_INC: assert property (head |=> loss_count ==
      (($past(loss_count) == LOSS_MAX) ? LOSS_MAX : $past(loss_count) + 4'h1))
      else $error("loss count step wrong");
   AST_LOSS_CLR: assert property (in_valid && in_ready && in_first && !frame_lost
      |=> loss_count == 4'h0) else $error("loss count not cleared");
   AST_PITCH_HOLD: assert property (head && loss_count != 4'h0 |=> $stable(pitch_usable))
      else $error("verdict changed within a loss run");
   AST_SILENCE: assert property (head && loss_count == 4'h0 && prior_energy < ENER_FLOOR
      |=> !pitch_usable) else $error("silence judged usable");
   AST_FIRST_ZC: assert property (head && loss_count == 4'h0 && zlim |=> !pitch_usable)
      else $error("busy first loss judged usable");
endmodule : lfwa_adjust_chk

bind lfwa_adjust lfwa_adjust_chk #(.FRAME_LEN(FRAME_LEN)) lfwa_adjust_chk_i (.*);

// file: sim/lfwa_upstream_model.sv
/* Upstream decoder model: per frame a prior spectrum, then the frame samples.
   Assumes calls from the bench at falling edges; lines change only then. */
`timescale 1ns/100ps
module lfwa_upstream_model
   import lfwa_pkg::*;
#(
   parameter int L = 16
)
(
   // Clock and flow control
   input  wire logic                 clk_sys,
   input  wire logic                 in_ready,
   // Samples and descriptor
   output      logic                 in_valid,
   output      logic signed   [15:0] in_sample,
   output      logic                 in_first,
   output      logic                 frame_lost,
   output      logic [$clog2(L)-1:0] pitch_period,
   output      logic          [15:0] peak_corr,
   output      logic          [15:0] prior_energy,
   output      logic           [8:0] prior_crossings,
   output      logic           [8:0] first_loss_crossing_count,
   // Spectrum
   output      logic                 spec_valid,
   output      logic signed   [15:0] spec_coef,
   output      logic                 spec_last
);
   logic signed [15:0] sent [L];

   // Idle lines; pitch of half a frame puts the first harmonic in bin 4
   initial
   begin
      {in_valid, in_first, frame_lost, spec_valid, spec_last} = 5'h00;
      {in_sample, spec_coef, peak_corr, prior_energy} = 64'h0;
      {prior_crossings, first_loss_crossing_count} = 18'h0;
      pitch_period = ($clog2(L))'(L / 2);
   end

   // Descriptor holds from the first bin to the last sample
   task automatic frame(input logic lost, input logic [15:0] e, input logic [8:0] zc,
                        input logic [8:0] fc, input logic [15:0] corr, input logic harm,
                        input logic [15:0] base);
      int i;
      int w;
      {frame_lost, prior_energy, prior_crossings} = {lost, e, zc};
      {first_loss_crossing_count, peak_corr} = {fc, corr};
      for (i = 0; i < L; i++)
      begin
         {spec_valid, spec_last} = {1'b1, i == L - 1};
         spec_coef = (harm && i != 4) ? 16'h0000 : 16'h0100;
         @(negedge clk_sys);
      end
      {spec_valid, spec_last} = 2'h0;
      spec_coef = ~spec_coef;
      for (i = 0; i < L; i++)
      begin
         sent[i] = base + 16'(i * 291);
         {in_valid, in_first, in_sample} = {1'b1, i == 0, sent[i]};
         for (w = 0; w < 1000 && !in_ready; w++)
            @(negedge clk_sys);
         @(negedge clk_sys);
      end
      in_valid = 1'b0;
      in_sample = ~in_sample;
   endtask : frame
endmodule : lfwa_upstream_model

// file: sim/lfwa_adjust_test.sv
/* Bench for lfwa_adjust: table of first-loss verdicts, a long loss run, a stalled frame.
   Assumes the upstream model drives the stream and this bench drains it. */
`timescale 1ns/100ps
module lfwa_adjust_test
   import lfwa_pkg::*;
;
   localparam int L = 16;
   typedef struct packed {logic [15:0] e; logic [8:0] zc; logic [8:0] fc;
                          logic [15:0] corr; logic harm; logic exp;} lfwa_row_t;
   // Row 0 is the good frame that opens each case
   lfwa_row_t rows [10] = '{'{16'h3B6D, 9'h064, 9'h000, 16'h0000, 1'b0, 1'b0},
      '{16'h3100, 9'h010, 9'h000, 16'h7FFF, 1'b0, 1'b0}, '{16'h3280, 9'h010, 9'h000, 16'h4000, 1'b0, 1'b0},
      '{16'h3C00, 9'h010, 9'h047, 16'h7FFF, 1'b0, 1'b0}, '{16'h3C00, 9'h010, 9'h046, 16'h7000, 1'b0, 1'b1},
      '{16'h3C00, 9'h065, 9'h000, 16'h6000, 1'b0, 1'b0}, '{16'h3400, 9'h010, 9'h000, 16'h6000, 1'b0, 1'b0},
      '{16'h3D80, 9'h010, 9'h000, 16'h5000, 1'b0, 1'b1}, '{16'h3B00, 9'h010, 9'h000, 16'h4000, 1'b1, 1'b1},
      '{16'h3B00, 9'h010, 9'h000, 16'h4000, 1'b0, 1'b0}};
   logic               clk_sys = 1'b0, rst_n = 1'b0, out_ready = 1'b1;
   logic               in_valid, in_ready, in_first, frame_lost, spec_valid, spec_last;
   logic               out_valid, out_first, pitch_usable;
   logic         [3:0] pitch_period, loss_count;
   logic        [15:0] peak_corr, prior_energy;
   logic         [8:0] prior_crossings, first_loss_crossing_count;
   logic signed [15:0] in_sample, spec_coef, out_sample;
   logic signed [15:0] got [$];
   int                 bad_count = 0, n_checks = 0, k, first_at = -1;

   // 125 MHz
   always #4 clk_sys = ~clk_sys;

   lfwa_adjust #(.FRAME_LEN(L)) lfwa_adjust_i (.*);
   lfwa_upstream_model #(.L(L)) lfwa_upstream_model_i (.*);

   // Every delivered word, in order, and where the frame start flag showed
   always @(posedge clk_sys)
   begin
      if (rst_n && out_valid && out_ready)
      begin
         if (out_first)
            first_at = got.size();
         got.push_back(out_sample);
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   // Bounded wait for a whole frame; a pass frame must equal what was sent
   task automatic frame_out(input logic pass, input logic head);
      int w;
      for (w = 0; w < 3000 && got.size() < L; w++)
         @(negedge clk_sys);
      if (got.size() < L)
      begin
         check("output count", got.size(), L);
         final_report();
      end
      check("first flag position", first_at, 0);
      // A first loss opens on the input sample at full weight with zero level: sample 0 is the input
      for (w = 0; w < (pass ? L : int'(head)); w++)
         check("pass sample", got[w], lfwa_upstream_model_i.sent[w]);
      got.delete();
      first_at = -1;
   endtask : frame_out

   task automatic run(input logic lost, input lfwa_row_t r, input logic [15:0] b, input logic p,
                      input logic h = 1'b0);
      lfwa_upstream_model_i.frame(lost, r.e, r.zc, r.fc, r.corr, r.harm, b);
      frame_out(p, h);
   endtask : run

   // Reset, verdict table, long loss run, stalled receiver
   initial
   begin
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      check("reset state", {in_ready, out_valid, pitch_usable, loss_count}, 7'h40);
      $display("reset done");
      for (k = 1; k < 10; k++)
      begin
         run(1'b0, rows[0], 16'h0100, 1'b0);
         run(1'b1, rows[k], 16'(k) << 12, !rows[k].exp, 1'b1);
         check("verdict", pitch_usable, rows[k].exp);
         $display("row %0d done", k);
      end
      run(1'b0, rows[0], 16'h0200, 1'b0);
      for (k = 1; k <= 16; k++)
      begin
         run(1'b1, (k == 1) ? rows[4] : rows[1], 16'(k) << 8, k > 4, k == 1);
         check("loss count", loss_count, (k > 15) ? 15 : k);
         check("reused verdict", pitch_usable, 1'b1);
      end
      $display("loss run done");
      rst_n = 1'b0;
      @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      check("mid reset", {in_ready, out_valid, pitch_usable, loss_count}, 7'h40);
      $display("mid reset done");
      run(1'b0, rows[0], 16'h0300, 1'b0);
      out_ready = 1'b0;
      fork
         lfwa_upstream_model_i.frame(1'b1, 16'h3100, 9'h010, 9'h000, 16'h7FFF, 1'b0, 16'h0400);
         begin
            repeat (40) @(negedge clk_sys);
            check("stall fill", {in_ready, 8'(got.size())}, 9'h000);
            out_ready = 1'b1;
         end
      join
      frame_out(1'b1, 1'b0);
      $display("stall done");
      final_report();
   end
endmodule : lfwa_adjust_test
